//--- arco_pkg.sv
/*
 * Shared constants and types of the converter's reset, clock-ratio and
 * output-pin control block: register map, reset values, clock ratios,
 * state and mode codes.
 * Assumes a 32-bit AXI4-Lite register bus and a single master clock.
 */
// Notes on behaviour
// RULE_01 - Each channel's 6-bit modulator word feeds the decimator and the stream engine.
// RULE_02 - Modulator words become one-bit streams sent on their own pins.
// RULE_03 - PCM and one-bit stream outputs may run at the same time.
// RULE_04 - With direct modulator output on, PCM and stream outputs are unavailable.
// RULE_05 - Master clock is 256, 128 or 64 times the sample rate.
// RULE_06 - Stream mode: master clock is 4x bit rate (64x) or 2x (128x).
// RULE_07 - Direct modulator output: master clock is twice the word rate.
// RULE_08 - Reset pin is active low; its release starts initialisation.
// RULE_09 - Device stays powered down while the reset pin is held low.
// RULE_10 - The master clock must run before the reset pin is released.
// RULE_11 - Hold states, PCM master: word clock, bit clock and data driven low.
// RULE_12 - Hold states, PCM slave: only data driven low, clocks stay inputs.
// RULE_13 - Hold states, stream on: left, right data and stream clock low.
// RULE_14 - Hold states, modulator on: word clock, clock out, six bits low.
// RULE_15 - Hold states apply only to interfaces whose enable is set.
// RULE_16 - Disabled modes drive low; disabled modulator pins revert to inputs.
// RULE_17 - Two rate selects pick normal, double, quad; both high is reserved.
// RULE_18 - Enabled outputs stay in hold states for a set count after release.

package arco_pkg;

   // Register byte offsets
   localparam logic [4:0]  OFS_CTRL    = 5'h00;
   localparam logic [4:0]  OFS_INIT    = 5'h04;
   localparam logic [4:0]  OFS_STATUS  = 5'h08;
   localparam logic [4:0]  OFS_RATIO   = 5'h0C;

   // Reset values
   localparam logic [6:0]  CTRL_RST    = 7'h00;
   localparam logic [15:0] INIT_RST    = 16'h0400;

   // Status field positions
   localparam int          STAT_ERR    = 5;

   // Master clocks per frame for each sampling mode
   localparam logic [9:0]  RATIO_NORMAL = 10'h100;
   localparam logic [9:0]  RATIO_DOUBLE = 10'h080;
   localparam logic [9:0]  RATIO_QUAD   = 10'h040;

   // Last count of the stream bit divider
   localparam logic [1:0]  STREAM_LAST_64X  = 2'h3;
   localparam logic [1:0]  STREAM_LAST_128X = 2'h1;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT  = 2'b01,
      ST_RUN   = 2'b10
   } arco_state_t;

   // Encoded as {rate_select_high, rate_select_low}
   typedef enum logic [1:0] {
      RATE_NORMAL = 2'b00,
      RATE_DOUBLE = 2'b01,
      RATE_QUAD   = 2'b10,
      RATE_RSVD   = 2'b11
   } arco_rate_t;

   typedef struct packed {
      logic stream_128;
      logic rate_select_high;
      logic rate_select_low;
      logic slave;
      logic modulator_output_enable;
      logic one_bit_stream_enable;
      logic pcm_output_enable;
   } arco_ctrl_t;

endpackage : arco_pkg

//--- arco_init_timer.sv
/*
 * Initialisation hold timer: counts master clocks while running and
 * flags when the programmed length is reached.
 * Assumes the caller clears it before each new initialisation.
 */
`timescale 1ns/1ps
`default_nettype none

module arco_init_timer
   import arco_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Control
   input  wire logic             i_clear,
   input  wire logic [CNT_W-1:0] i_length,
   // Status
   output logic                  o_done
);

   logic [CNT_W-1:0] count;

   assign o_done = (count >= i_length);

   always_ff @(posedge i_clk) begin
      if (i_rst || i_clear) begin
         count <= '0;
      end else if (!o_done) begin
         count <= count + 1'b1;
      end
   end

endmodule : arco_init_timer

`default_nettype wire

//--- arco_requant.sv
/*
 * First-order error-feedback requantiser: turns signed multi-bit
 * modulator words into a one-bit stream, one bit per tick.
 * Assumes the word is two's complement and stable at the tick.
 */
`timescale 1ns/1ps
`default_nettype none

module arco_requant
   import arco_pkg::*;
#(
   parameter int MOD_W = 6
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Word in
   input  wire logic             i_tick,
   input  wire logic [MOD_W-1:0] i_word,
   // Bit out
   output logic                  o_bit
);

   localparam logic signed [MOD_W+2:0] FULL =
      {{3{1'b0}}, 1'b1, {(MOD_W-1){1'b0}}};

   logic signed [MOD_W+2:0] acc;
   logic signed [MOD_W+2:0] sum;

   // Headroom of three bits keeps the loop from wrapping
   assign sum = acc + {{3{i_word[MOD_W-1]}}, i_word};

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         acc   <= '0;
         o_bit <= 1'b0;
      end else if (i_tick) begin
         acc   <= sum[MOD_W+2] ? sum + FULL : sum - FULL;
         o_bit <= ~sum[MOD_W+2];
      end
   end

endmodule : arco_requant

`default_nettype wire

//--- arco_ctrl.sv
/*
 * Reset, initialisation and output-pin control of a two-channel
 * delta-sigma converter, with an AXI4-Lite register slave.
 * Assumes i_clk is the master clock and all inputs are synchronous to it;
 * the decimator and serial framer sit outside.
 */
`timescale 1ns/1ps
`default_nettype none

module arco_ctrl
   import arco_pkg::*;
#(
   parameter int MOD_W  = 6,
   parameter int ADDR_W = 5
) (
   // Clock and system reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Reset and power-down pin, active low
   input  wire logic              i_reset_n,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   // Modulator words in
   input  wire logic [MOD_W-1:0]  i_mod_left,
   input  wire logic [MOD_W-1:0]  i_mod_right,
   input  wire logic              i_mod_valid,
   // Feed to the decimation filter
   output logic [MOD_W-1:0]       o_dec_left,
   output logic [MOD_W-1:0]       o_dec_right,
   output logic                   o_dec_valid,
   // PCM serial port
   input  wire logic              i_pcm_serial_data,
   input  wire logic              i_frame_word_clock,
   output logic                   o_frame_word_clock,
   output logic                   o_frame_word_clock_oe,
   output logic                   o_serial_bit_clock,
   output logic                   o_serial_bit_clock_oe,
   output logic                   o_pcm_data,
   // One-bit stream port
   output logic                   o_stream_left_data,
   output logic                   o_stream_right_data,
   output logic                   o_stream_bit_clock,
   // Direct modulator port
   output logic                   o_modulator_word_clock_out,
   output logic                   o_modulator_master_clock_out,
   output logic [MOD_W-1:0]       o_modulator_data_bits,
   output logic                   o_modulator_pins_oe
);

   arco_state_t state;
   arco_state_t next_state;
   arco_ctrl_t  ctrl;
   logic [15:0] init_len;
   logic        ratio_err;
   logic [15:0] ratio_meas;
   logic        init_done;

   // Mode decode
   wire arco_rate_t rate = arco_rate_t'({ctrl.rate_select_high,
                                          ctrl.rate_select_low}); // RULE_17
   wire logic mod_on    = ctrl.modulator_output_enable;
   wire logic pcm_on    = ctrl.pcm_output_enable & ~mod_on;      // RULE_04
   wire logic stream_on = ctrl.one_bit_stream_enable & ~mod_on;  // RULE_03
   wire logic master    = pcm_on & ~ctrl.slave;
   wire logic hold      = (state != ST_RUN);

   // Reserved code falls back to the normal divider
   wire logic [9:0] ratio = (rate == RATE_DOUBLE) ? RATIO_DOUBLE :
                            (rate == RATE_QUAD)   ? RATIO_QUAD :
                                                    RATIO_NORMAL; // RULE_05

   // Reset and initialisation sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET: next_state = ST_INIT;                 // RULE_08 RULE_10
         ST_INIT:  if (init_done) next_state = ST_RUN;   // RULE_18
         ST_RUN:   next_state = ST_RUN;
         default:  next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_reset_n) begin
         state <= ST_RESET;                              // RULE_08 RULE_09
      end else begin
         state <= next_state;
      end
   end

   arco_init_timer #(
      .CNT_W    (16)
   ) u_timer (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_clear  (state != ST_INIT),
      .i_length (init_len),
      .o_done   (init_done)
   );

   // Clock dividers; held at zero so every interface starts in phase
   logic [9:0] div_cnt;
   logic [1:0] sdiv;
   wire logic [1:0] s_last = ctrl.stream_128 ? STREAM_LAST_128X
                                             : STREAM_LAST_64X; // RULE_06
   wire logic s_tick  = (sdiv == s_last);
   wire logic s_high  = ctrl.stream_128 ? sdiv[0] : sdiv[1];
   wire logic [9:0] half = {1'b0, ratio[9:1]};
   wire logic frame_hi = (div_cnt < half);

   always_ff @(posedge i_clk) begin
      if (i_rst || hold) begin
         div_cnt <= '0;
         sdiv    <= '0;
      end else begin
         div_cnt <= (div_cnt >= ratio - 10'h001) ? 10'h000
                                                 : div_cnt + 10'h001;
         sdiv    <= s_tick ? 2'h0 : sdiv + 2'h1;
      end
   end

   // Latest word of each channel
   logic [MOD_W-1:0] word_l;
   logic [MOD_W-1:0] word_r;
   logic             mod_phase;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         word_l    <= '0;
         word_r    <= '0;
         mod_phase <= 1'b0;
      end else begin
         if (i_mod_valid) begin
            word_l <= i_mod_left;                        // RULE_01
            word_r <= i_mod_right;
         end
         mod_phase <= hold ? 1'b0 : ~mod_phase;          // RULE_07
      end
   end

   // One-bit stream engine, one converter per channel
   logic [1:0]       stream_bit;
   logic [MOD_W-1:0] ch_word [2];
   assign ch_word[0] = word_l;
   assign ch_word[1] = word_r;

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      arco_requant #(
         .MOD_W  (MOD_W)
      ) u_requant (
         .i_clk  (i_clk),
         .i_rst  (i_rst),
         .i_tick (s_tick & stream_on & ~hold),           // RULE_02
         .i_word (ch_word[ch]),
         .o_bit  (stream_bit[ch])
      );
   end

   // Output pins: disabled or held interfaces drive low; disabled modulator pins and slave clock pins are released
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_dec_left                   <= '0;
         o_dec_right                  <= '0;
         o_dec_valid                  <= 1'b0;
         o_frame_word_clock           <= 1'b0;
         o_frame_word_clock_oe        <= 1'b1;
         o_serial_bit_clock           <= 1'b0;
         o_serial_bit_clock_oe        <= 1'b1;
         o_pcm_data                   <= 1'b0;
         o_stream_left_data           <= 1'b0;
         o_stream_right_data          <= 1'b0;
         o_stream_bit_clock           <= 1'b0;
         o_modulator_word_clock_out   <= 1'b0;
         o_modulator_master_clock_out <= 1'b0;
         o_modulator_data_bits        <= '0;
         o_modulator_pins_oe          <= 1'b0;
      end else begin
         o_dec_left            <= i_mod_left;            // RULE_01
         o_dec_right           <= i_mod_right;
         o_dec_valid           <= i_mod_valid & ~hold;
         o_frame_word_clock    <= master & ~hold & frame_hi;  // RULE_11
         o_serial_bit_clock    <= master & ~hold & div_cnt[0];
         o_frame_word_clock_oe <= ~(pcm_on & ctrl.slave);     // RULE_12
         o_serial_bit_clock_oe <= ~(pcm_on & ctrl.slave);
         o_pcm_data            <= pcm_on & ~hold & i_pcm_serial_data;
         o_stream_left_data    <= stream_on & ~hold & stream_bit[0]; // RULE_13
         o_stream_right_data   <= stream_on & ~hold & stream_bit[1];
         o_stream_bit_clock    <= stream_on & ~hold & s_high;
         o_modulator_word_clock_out   <= mod_on & ~hold & ~mod_phase;
         o_modulator_master_clock_out <= mod_on & ~hold & mod_phase; // RULE_14
         o_modulator_data_bits <= (mod_on & ~hold)
                                  ? (mod_phase ? word_r : word_l)
                                  : '0;                  // RULE_15
         o_modulator_pins_oe   <= mod_on;                // RULE_16
      end
   end

   // Slave clock ratio check: frame period against the selected mode
   logic        fwc_prev;
   logic        fwc_seen;
   logic [15:0] per_cnt;
   wire logic   fwc_rise  = i_frame_word_clock & ~fwc_prev;
   wire logic   chk_slave = pcm_on & ctrl.slave & ~hold;
   wire logic   ratio_bad = chk_slave & fwc_rise & fwc_seen &
                            (per_cnt != {6'h00, ratio}); // RULE_05

   always_ff @(posedge i_clk) begin
      if (i_rst || !chk_slave) begin
         fwc_prev <= 1'b1;
         fwc_seen <= 1'b0;
         per_cnt  <= 16'h0001;
      end else begin
         fwc_prev <= i_frame_word_clock;
         if (fwc_rise) begin
            fwc_seen <= 1'b1;
            per_cnt  <= 16'h0001;
         end else if (per_cnt != 16'hFFFF) begin
            per_cnt  <= per_cnt + 16'h0001;
         end
      end
   end

   // AXI4-Lite slave: address and data taken together, one of each at once
   wire logic wr_go = i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
   wire logic wr_do = o_awready;
   wire logic rd_go = i_arvalid & ~o_arready & ~o_rvalid;
   wire logic rd_do = o_arready;
   wire logic w_ctrl = (i_awaddr == OFS_CTRL);
   wire logic w_init = (i_awaddr == OFS_INIT);
   wire logic w_stat = (i_awaddr == OFS_STATUS);
   wire logic w_map  = w_ctrl | w_init | w_stat | (i_awaddr == OFS_RATIO);
   wire logic r_map  = (i_araddr == OFS_CTRL) | (i_araddr == OFS_INIT) |
                       (i_araddr == OFS_STATUS) | (i_araddr == OFS_RATIO);
   wire logic err_clr = wr_do & w_stat & i_wstrb[0] & i_wdata[STAT_ERR];
   wire logic [31:0] rd_mux =
      (i_araddr == OFS_CTRL)   ? {25'h0000000, ctrl} :
      (i_araddr == OFS_INIT)   ? {16'h0000, init_len} :
      (i_araddr == OFS_STATUS) ? {26'h0000000, ratio_err,
                                  (rate == RATE_RSVD), rate, state} :
      (i_araddr == OFS_RATIO)  ? {16'h0000, ratio_meas} : 32'h00000000;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rresp   <= RESP_OKAY;
         o_rdata   <= 32'h00000000;
      end else begin
         o_awready <= wr_go;
         o_wready  <= wr_go;
         if (wr_do) begin
            o_bvalid <= 1'b1;
            o_bresp  <= w_map ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
         o_arready <= rd_go;
         if (rd_do) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_mux;
            o_rresp  <= r_map ? RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Registers; a new mismatch wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl       <= arco_ctrl_t'(CTRL_RST);
         init_len   <= INIT_RST;
         ratio_err  <= 1'b0;
         ratio_meas <= 16'h0000;
      end else begin
         if (wr_do && w_ctrl && i_wstrb[0]) begin
            ctrl <= arco_ctrl_t'(i_wdata[6:0]);
         end
         if (wr_do && w_init && i_wstrb[0]) begin
            init_len[7:0] <= i_wdata[7:0];               // RULE_18
         end
         if (wr_do && w_init && i_wstrb[1]) begin
            init_len[15:8] <= i_wdata[15:8];
         end
         if (ratio_bad) begin
            ratio_err <= 1'b1;
         end else if (err_clr) begin
            ratio_err <= 1'b0;
         end
         if (chk_slave && fwc_rise && fwc_seen) begin
            ratio_meas <= per_cnt;
         end
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   logic [15:0] hlp_init;
   always_ff @(posedge i_clk) begin
      if (i_rst || state != ST_INIT) begin
         hlp_init <= 16'h0000;
      end else begin
         hlp_init <= hlp_init + 16'h0001;
      end
   end

   chk_pin_reset: assert property ( // RULE_08
      !i_reset_n |=> state == ST_RESET ##1 state != ST_RUN)
      else $error("reset pin did not force reset");
   chk_init_len: assert property ( // RULE_18
      (state == ST_INIT && next_state == ST_RUN && $stable(init_len))
      |-> hlp_init == init_len)
      else $error("init hold length wrong");
   chk_dec_feed: assert property ( // RULE_01
      (i_mod_valid && !hold)
      |=> o_dec_valid && o_dec_left == $past(i_mod_left))
      else $error("decimator feed lost a word");
   chk_mod_excl: assert property ( // RULE_04
      mod_on |=> !o_pcm_data && !o_stream_bit_clock && !o_stream_left_data)
      else $error("pcm or stream active with modulator out");
   chk_hold_master: assert property ( // RULE_11
      (hold && master) |=> o_frame_word_clock_oe && !o_frame_word_clock
                           && !o_serial_bit_clock && !o_pcm_data)
      else $error("master port not low in hold");
   chk_hold_slave: assert property ( // RULE_12
      (hold && pcm_on && ctrl.slave)
      |=> !o_pcm_data && !o_frame_word_clock_oe && !o_serial_bit_clock_oe)
      else $error("slave port hold state wrong");
   chk_hold_stream: assert property ( // RULE_13
      (hold && stream_on) |=> !o_stream_left_data && !o_stream_right_data
                              && !o_stream_bit_clock)
      else $error("stream port not low in hold");
   chk_hold_mod: assert property ( // RULE_14
      (hold && mod_on) |=> o_modulator_pins_oe && o_modulator_data_bits == '0
         && !o_modulator_word_clock_out && !o_modulator_master_clock_out)
      else $error("modulator port not low in hold");
   chk_mod_release: assert property ( // RULE_16
      !mod_on |=> !o_modulator_pins_oe)
      else $error("modulator pins driven while disabled");

endmodule : arco_ctrl

`default_nettype wire

//--- arco_host.sv
/* Model of the external controller: drives the reset pin and, in slave
   PCM, the frame word clock.
   Assumes the bench keeps the master clock running before any release. */
`timescale 1ns/1ps
`default_nettype none

module arco_host
   import arco_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Bench commands
   input  wire logic       i_release,
   input  wire logic [9:0] i_period,
   // Device pins
   output logic            o_reset_n,
   output logic            o_frame_word_clock
);
   logic [9:0] cnt;
   wire        wrap = (cnt + 10'h001) >= i_period;
   wire        high = (i_period != 10'h000) && (cnt < (i_period >> 1));

   // Period zero parks the word clock low between runs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_reset_n          <= 1'b0;
         cnt                <= 10'h000;
         o_frame_word_clock <= 1'b0;
      end else begin
         o_reset_n          <= i_release;
         cnt                <= wrap ? 10'h000 : cnt + 10'h001;
         o_frame_word_clock <= high;
      end
   end
endmodule : arco_host
`default_nettype wire

//--- test_arco_ctrl.sv
/* Self-checking bench of the reset and output-pin control block.
   Assumes arco_pkg and arco_host are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module test_arco_ctrl
   import arco_pkg::*;
;
   localparam int INIT_LEN = 2;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        rel = 1'b0;
   logic [9:0]  wper = '0;
   logic [4:0]  i_awaddr = '0, i_araddr = '0;
   logic [31:0] i_wdata = '0;
   logic [3:0]  i_wstrb = 4'hF;
   logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic        i_arvalid = 1'b0, i_rready = 1'b0;
   logic [5:0]  i_mod_left = '0, i_mod_right = '0;
   logic        i_mod_valid = 1'b0, i_pcm_serial_data = 1'b0;
   logic        i_reset_n, i_frame_word_clock;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]  o_bresp, o_rresp;
   logic [31:0] o_rdata;
   logic [5:0]  o_dec_left, o_dec_right, o_modulator_data_bits;
   logic        o_dec_valid, o_frame_word_clock, o_frame_word_clock_oe;
   logic        o_serial_bit_clock, o_serial_bit_clock_oe, o_pcm_data;
   logic        o_stream_left_data, o_stream_right_data, o_stream_bit_clock;
   logic        o_modulator_word_clock_out, o_modulator_master_clock_out;
   logic        o_modulator_pins_oe;
   int          fail_count = 0;
   int          n_compared = 0;
   int          seed = 32'h25E7;
   logic [2:0]  pq = '0;
   int          pn [3] = '{0, 0, 0};
   int          per [3] = '{0, 0, 0};
   wire  [2:0]  pv = {o_modulator_word_clock_out, o_stream_bit_clock,
                      o_frame_word_clock};
   wire  [5:0]  pcm_strm = {o_pcm_data, o_frame_word_clock,
      o_serial_bit_clock, o_stream_left_data, o_stream_right_data,
      o_stream_bit_clock};
   wire  [8:0]  modp = {o_modulator_word_clock_out,
      o_modulator_master_clock_out, o_modulator_data_bits, o_dec_valid};

   arco_host host (
      .i_clk, .i_rst, .i_release(rel), .i_period(wper),
      .o_reset_n(i_reset_n), .o_frame_word_clock(i_frame_word_clock)
   );
   arco_ctrl dut (
      .i_clk, .i_rst, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready,
      .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
      .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
      .o_rvalid, .i_rready, .i_mod_left, .i_mod_right, .i_mod_valid,
      .o_dec_left, .o_dec_right, .o_dec_valid, .i_pcm_serial_data,
      .i_frame_word_clock, .o_frame_word_clock, .o_frame_word_clock_oe,
      .o_serial_bit_clock, .o_serial_bit_clock_oe, .o_pcm_data,
      .o_stream_left_data, .o_stream_right_data, .o_stream_bit_clock,
      .o_modulator_word_clock_out, .o_modulator_master_clock_out,
      .o_modulator_data_bits, .o_modulator_pins_oe
   );

   initial forever #12.5 i_clk = ~i_clk;

   // Rise-to-rise period of word, stream and modulator clocks
   always @(negedge i_clk) begin
      for (int k = 0; k < 3; k++) begin
         pq[k] <= pv[k];
         pn[k] <= (pv[k] && !pq[k]) ? 1 : pn[k] + 1;
         if (pv[k] && !pq[k]) per[k] <= pn[k];
      end
   end

   function automatic logic [1:0] oe_exp(input logic [31:0] c);
      return {2{~(c[0] & c[3] & ~c[2])}};
   endfunction : oe_exp

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge i_clk);
      i_awaddr  <= a;
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      i_bready  <= 1'b1;
      // Each channel is let go at its own handshake
      while (!(aw_done && w_done)) begin
         @(posedge i_clk);
         if (!aw_done && o_awready === 1'b1) begin
            aw_done = 1'b1;
            i_awvalid <= 1'b0;
         end
         if (!w_done && o_wready === 1'b1) begin
            w_done = 1'b1;
            i_wvalid <= 1'b0;
         end
      end
      while (o_bvalid !== 1'b1) @(posedge i_clk);
      i_bready  <= 1'b0;
      chk({30'h0, o_bresp}, {30'h0, er});
   endtask : wr

   task automatic rdc(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er);
      @(posedge i_clk);
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      i_rready  <= 1'b1;
      do @(posedge i_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      while (o_rvalid !== 1'b1) @(posedge i_clk);
      i_rready  <= 1'b0;
      chk({o_rresp, o_rdata & m}, {er, e});
   endtask : rdc

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      wrap_up();
   end

   initial begin : main
      logic [31:0] c;
      int          n;
      logic        b;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      rdc(OFS_CTRL, '1, {25'h0, CTRL_RST}, RESP_OKAY);
      rdc(OFS_INIT, '1, {16'h0, INIT_RST}, RESP_OKAY);
      rdc(5'h10, '1, 32'h0, RESP_SLVERR);
      wr(5'h14, 32'hFFFFFFFF, RESP_SLVERR);
      wr(OFS_INIT, INIT_LEN, RESP_OKAY);
      // Pin held low: twelve random mixes of enables must sit in hold states
      for (int k = 0; k < 12; k++) begin
         c = $random(seed);
         wr(OFS_CTRL, c, RESP_OKAY);
         {i_mod_left, i_mod_right, i_pcm_serial_data} <= c[31:19];
         i_mod_valid <= 1'b1;
         repeat (3) @(negedge i_clk);
         chk({pcm_strm, modp}, 0);
         chk({o_frame_word_clock_oe, o_serial_bit_clock_oe}, oe_exp(c));
         chk(o_modulator_pins_oe, c[2]);
      end
      wr(OFS_CTRL, 32'h30, RESP_OKAY);
      rdc(OFS_STATUS, 32'h1F, 32'h1C, RESP_OKAY);
      wr(OFS_CTRL, 32'h03, RESP_OKAY);
      rel <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_dec_valid !== 1'b1 && n < 40);
      chk(n, INIT_LEN + 5);
      rdc(OFS_STATUS, 32'h3, 32'h2, RESP_OKAY);
      repeat (8) begin
         c = $random(seed);
         @(posedge i_clk);
         {i_mod_left, i_mod_right} <= c[11:0];
         repeat (2) @(negedge i_clk);
         chk({o_dec_valid, o_dec_left, o_dec_right}, {1'b1, c[11:0]});
      end
      for (int r = 0; r < 3; r++) begin
         wr(OFS_CTRL, {r[0], r[1:0], 4'h3}, RESP_OKAY);
         {i_mod_left, i_mod_right, i_pcm_serial_data} <= {6'h20, 6'h00, r[0]};
         repeat (700) @(posedge i_clk);
         chk(per[0], 256 >> r);
         chk(per[1], r[0] ? 2 : 4);
         // Full negative word gives zeros, a zero word alternates per bit
         @(negedge i_clk);
         b = o_stream_right_data;
         repeat (r[0] ? 2 : 4) @(negedge i_clk);
         chk({o_stream_left_data, o_stream_right_data}, {1'b0, ~b});
         chk(o_pcm_data, r[0]);
      end
      wr(OFS_CTRL, 32'h07, RESP_OKAY);
      {i_mod_left, i_mod_right} <= 12'hA5C;
      repeat (10) @(negedge i_clk);
      chk(per[2], 2);
      chk(pcm_strm, 0);
      chk({o_modulator_master_clock_out, o_modulator_data_bits},
          o_modulator_word_clock_out ? {1'b0, 6'h29} : {1'b1, 6'h1C});
      // Slave port: word clock from the host, ratio checked per frame
      wper <= 10'h100;
      wr(OFS_CTRL, 32'h09, RESP_OKAY);
      repeat (900) @(posedge i_clk);
      chk({o_frame_word_clock_oe, o_serial_bit_clock_oe}, 0);
      wr(OFS_STATUS, 32'h20, RESP_OKAY);
      repeat (600) @(posedge i_clk);
      rdc(OFS_STATUS, 32'h20, 32'h0, RESP_OKAY);
      rdc(OFS_RATIO, 32'hFFFF, 32'h100, RESP_OKAY);
      wper <= 10'h0C8;
      repeat (600) @(posedge i_clk);
      rdc(OFS_STATUS, 32'h20, 32'h20, RESP_OKAY);
      rdc(OFS_RATIO, 32'hFFFF, 32'hC8, RESP_OKAY);
      rel <= 1'b0;
      repeat (4) @(negedge i_clk);
      chk({o_pcm_data, o_dec_valid}, 0);
      rdc(OFS_STATUS, 32'h3, 32'h0, RESP_OKAY);
      wrap_up();
   end
endmodule : test_arco_ctrl
`default_nettype wire
